// ===== hw/bb_cfg_pkg.sv
// package for the receive/transmit, converter test and agc configuration bank
// assumes a 100 MHz core clock and byte-wide registers
package bb_cfg_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam int          NUM_REGS        = 6;

  // register addresses
  localparam logic [7:0]  RX_TX_CONFIGURE_ADDR              = 8'h16;
  localparam logic [7:0]  CONVERTER_CLOCK_TEST_ADDR         = 8'h18;
  localparam logic [7:0]  POWER_DOWN_OVERRIDE_ADDR          = 8'h1A;
  localparam logic [7:0]  CONVERTER_FORMAT_AND_DAC_MUX_ADDR = 8'h1C;
  localparam logic [7:0]  AGC_GAIN_CLIP_ADDR                = 8'h1E;
  localparam logic [7:0]  AGC_SATURATION_COUNTS_ADDR        = 8'h20;

  // storage indices
  localparam logic [2:0]  IDX_RXTX = 3'h0;
  localparam logic [2:0]  IDX_CLK  = 3'h1;
  localparam logic [2:0]  IDX_PWR  = 3'h2;
  localparam logic [2:0]  IDX_FMT  = 3'h3;
  localparam logic [2:0]  IDX_CLIP = 3'h4;
  localparam logic [2:0]  IDX_SAT  = 3'h5;

  localparam logic [7:0]  REG_RESET_VALUE = 8'h00;

  // rx_tx_configure fields
  localparam int          CONT_CLK_BIT    = 7;
  localparam int          AC_COUPLE_BIT   = 6;
  localparam int          SHORT_PRE_BIT   = 4;
  localparam int          CCA_SAMPLED_BIT = 3;
  localparam int          PRECURSOR_LSB   = 0;
  localparam int          PRECURSOR_W     = 3;
  // converter_clock_test fields
  localparam int          CLK_SRC_BIT     = 7;
  localparam int          CLK_GATE_W      = 7;
  // power_down_override fields
  localparam int          MANUAL_PD_BIT   = 0;
  localparam int          PD_LSB          = 1;
  localparam int          PD_W            = 7;
  // converter_format_and_dac_mux fields
  localparam int          FORMAT_BIT      = 7;
  localparam int          DAC_SEL_LSB     = 4;
  localparam int          DAC_SEL_W       = 3;
  localparam int          TESTBUS_DAC_BIT = 3;
  localparam int          RFADC_DAC_BIT   = 2;
  localparam int          TRIM_HIGH_BIT   = 1;
  localparam int          TRIM_LOW_BIT    = 0;
  // agc fields
  localparam int          CLIP_W          = 7;
  localparam int          SAT_MID_LSB     = 4;
  localparam int          SAT_LOW_LSB     = 0;
  localparam int          SAT_W           = 4;

  typedef enum logic [2:0] {
    DAC_TX_FILTER, DAC_DOWNCONV, DAC_CHIP_TIMING, DAC_IQ_ADC,
    DAC_PICKER, DAC_CMF_WEIGHTS, DAC_TEST_BUS, DAC_CORRELATOR
  } dac_sel_t;

  // matched-filter weight scan
  localparam int          CMF_TAPS        = 16;
  localparam int          CMF_PHASE_W     = 5;

  // clear-channel slot timing
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          SLOT_NS         = 20000;
  localparam int          SAMPLE_LATE_NS  = 18700;
  localparam int          SAMPLE_EARLY_NS = 15800;
  localparam int          SLOT_CYCLES     = SLOT_NS / CLK_PERIOD_NS;
  localparam int          LATE_CYCLES     = (SAMPLE_LATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          EARLY_CYCLES    = (SAMPLE_EARLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SLOT_CNT_W      = 11;

endpackage

// ===== hw/cca_slot_if.sv
// bank to clear-channel slot timer signals
// assumes both ends share core_clk_in
`timescale 1ns/1ps
interface cca_slot_if;
  logic sampled_mode;
  logic sample_time_early;
  logic sample_pulse;
  modport timer (input sampled_mode, input sample_time_early, output sample_pulse);
  modport ctrl  (output sampled_mode, output sample_time_early, input sample_pulse);
endinterface

// ===== hw/cca_slot_timer.sv
// slot timer for sampled clear-channel assessment
// assumes one core clock
`timescale 1ns/1ps
module cca_slot_timer
  import bb_cfg_pkg::*;
(
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  cca_slot_if.timer slot
);

  logic [SLOT_CNT_W-1:0] slot_cnt_q;
  logic [SLOT_CNT_W-1:0] sample_at;

  assign sample_at = slot.sample_time_early ? SLOT_CNT_W'(EARLY_CYCLES - 1)
                                            : SLOT_CNT_W'(LATE_CYCLES - 1);

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      slot_cnt_q <= '0;
    else if (!slot.sampled_mode || slot_cnt_q == SLOT_CNT_W'(SLOT_CYCLES - 1))
      slot_cnt_q <= '0;
    else
      slot_cnt_q <= slot_cnt_q + SLOT_CNT_W'(1);
  end

  // one pulse per slot, at the chosen sample time
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      slot.sample_pulse <= 1'b0;
    else
      slot.sample_pulse <= slot.sampled_mode && slot_cnt_q == sample_at;
  end

endmodule

// ===== hw/baseband_rxtx_test_agc_config.sv
// configuration bank for receive/transmit, converter test and agc limits
// assumes all inputs are synchronous to core_clk_in
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps

// Functional notes
// - continuous bit keeps receive clocks running
// - coupling bit: 0 dc, 1 ac
// - short preamble test forces stored length
// - raw assessment follows detectors at once
// - sampled assessment updates once per slot
// - low three bits give precursor count
// - clock source bit selects serial input
// - per-converter clock gate, one disables
// - manual bit selects stored power-down controls
// - power-down bits assert their function high
// - format bit selects offset binary output
// - selector picks the i/q dac source
// - code 101 scans weights with sync
// - code 110 routes test bus to both
// - rf converter to rx dac beats test bus
// - attenuator accumulator clipped to zero..limit
// - two saturation thresholds, mid and low
// - unused clip bit stored, never acted upon
// - gating control chooses acquisition or detect
// - sample time bit: late or early
// - steps only when saturations exceed threshold
module baseband_rxtx_test_agc_config
  import bb_cfg_pkg::*;
#(
  parameter int CONV_W  = 6,
  parameter int SAT_CNT_W = 8
)(
  input  wire logic                     core_clk_in,
  input  wire logic                     rst_in,
  // register port
  input  wire logic [ADDR_W-1:0]        reg_addr_in,
  input  wire logic [DATA_W-1:0]        reg_wdata_in,
  input  wire logic                     reg_wr_in,
  input  wire logic                     reg_rd_in,
  output logic      [DATA_W-1:0]        reg_rdata_out,
  // receive clocks
  input  wire logic                     rx_clock_gating_in,
  input  wire logic                     detect_in,
  output logic                          rx_clk_run_out,
  output logic                          adc_ac_coupling_out,
  // preamble
  input  wire logic                     normal_short_preamble_reg_in,
  output logic                          tx_short_preamble_out,
  output logic                          rx_short_preamble_out,
  output logic                          use_preamble_length_reg_out,
  // clear channel assessment
  input  wire logic                     energy_detect_in,
  input  wire logic                     carrier_sense_in,
  input  wire logic                     signal_quality_in,
  input  wire logic [1:0]               cca_mode_in,
  input  wire logic                     cca_sample_early_in,
  output logic                          clear_channel_out,
  output logic [PRECURSOR_W-1:0]        channel_impulse_response_precursor_out,
  // converter clocks and power
  output logic                          conv_clk_from_serial_data_in_pin_out,
  output logic [CLK_GATE_W-1:0]         conv_clk_enable_out,
  input  wire logic                     transmit_power_enable_in,
  input  wire logic                     receive_power_enable_in,
  output logic [PD_W-1:0]               power_down_out,
  // converter samples
  input  wire logic [CONV_W-1:0]        adc_i_in,
  input  wire logic [CONV_W-1:0]        adc_q_in,
  input  wire logic [CONV_W-1:0]        adc_rf_in,
  output logic [CONV_W-1:0]             adc_i_out,
  output logic [CONV_W-1:0]             adc_q_out,
  output logic [CONV_W-1:0]             adc_rf_out,
  // dac sources
  input  wire logic [CONV_W-1:0]        tx_filter_i_in,
  input  wire logic [CONV_W-1:0]        tx_filter_q_in,
  input  wire logic [CONV_W-1:0]        downconv_i_in,
  input  wire logic [CONV_W-1:0]        downconv_q_in,
  input  wire logic [CONV_W-1:0]        chip_timing_accumulator_in,
  input  wire logic [CONV_W-1:0]        picker_winner_inphase_in,
  input  wire logic [CONV_W-1:0]        picker_winner_quadrature_in,
  input  wire logic [CMF_TAPS*CONV_W-1:0] channel_matched_filter_weights_in,
  input  wire logic [CONV_W-1:0]        correlator_i_in,
  input  wire logic [CONV_W-1:0]        correlator_q_in,
  input  wire logic [CONV_W-1:0]        test_bus_in,
  input  wire logic [CONV_W-1:0]        rx_dac_normal_in,
  input  wire logic [CONV_W-1:0]        tx_dac_normal_in,
  output logic [CONV_W-1:0]             i_dac_out,
  output logic [CONV_W-1:0]             q_dac_out,
  output logic [CONV_W-1:0]             rx_dac_out,
  output logic [CONV_W-1:0]             tx_dac_out,
  output logic                          reference_trim_high_out,
  output logic                          reference_trim_low_out,
  // agc
  input  wire logic                     agc_step_valid_in,
  input  wire logic signed [CLIP_W:0]   agc_step_in,
  output logic [CLIP_W-1:0]             agc_attenuation_out,
  input  wire logic [SAT_CNT_W-1:0]     iq_saturation_count_in,
  output logic                          agc_mid_step_out,
  output logic                          agc_low_step_out
);

  // address decode shared by writes and reads
  function automatic logic [3:0] decode(input logic [ADDR_W-1:0] addr);
    case (addr)
      RX_TX_CONFIGURE_ADDR:              decode = {1'b1, IDX_RXTX};
      CONVERTER_CLOCK_TEST_ADDR:         decode = {1'b1, IDX_CLK};
      POWER_DOWN_OVERRIDE_ADDR:          decode = {1'b1, IDX_PWR};
      CONVERTER_FORMAT_AND_DAC_MUX_ADDR: decode = {1'b1, IDX_FMT};
      AGC_GAIN_CLIP_ADDR:                decode = {1'b1, IDX_CLIP};
      AGC_SATURATION_COUNTS_ADDR:        decode = {1'b1, IDX_SAT};
      default:                           decode = 4'h0;
    endcase
  endfunction

  // two's complement to offset binary is a flip of the sign bit
  function automatic logic [CONV_W-1:0] fmt(input logic [CONV_W-1:0] s, input logic ob);
    fmt = {s[CONV_W-1] ^ ob, s[CONV_W-2:0]};
  endfunction

  logic [DATA_W-1:0] cfg_q [NUM_REGS];
  logic [3:0]        wr_dec;
  logic [3:0]        rd_dec;

  assign wr_dec = decode(reg_addr_in);
  assign rd_dec = wr_dec;

  // full byte stored, reserved and unused bits included
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        cfg_q[i] <= REG_RESET_VALUE;
    end
    else if (reg_wr_in && wr_dec[3])
      cfg_q[wr_dec[2:0]] <= reg_wdata_in;
  end

  // read data one cycle after the strobe, else zero
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      reg_rdata_out <= '0;
    else if (reg_rd_in && rd_dec[3])
      reg_rdata_out <= cfg_q[rd_dec[2:0]];
    else
      reg_rdata_out <= '0;
  end

  logic [DATA_W-1:0] rxtx;
  logic [DATA_W-1:0] clkt;
  logic [DATA_W-1:0] pwr;
  logic [DATA_W-1:0] fmtr;
  logic [DATA_W-1:0] clip;
  logic [DATA_W-1:0] sat;

  assign rxtx = cfg_q[IDX_RXTX];
  assign clkt = cfg_q[IDX_CLK];
  assign pwr  = cfg_q[IDX_PWR];
  assign fmtr = cfg_q[IDX_FMT];
  assign clip = cfg_q[IDX_CLIP];
  assign sat  = cfg_q[IDX_SAT];

  // receive clocks, coupling, preamble, precursor
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rx_clk_run_out                         <= 1'b0;
      adc_ac_coupling_out                    <= 1'b0;
      tx_short_preamble_out                  <= 1'b0;
      rx_short_preamble_out                  <= 1'b0;
      use_preamble_length_reg_out            <= 1'b0;
      channel_impulse_response_precursor_out <= '0;
    end
    else
    begin
      rx_clk_run_out <= rxtx[CONT_CLK_BIT] || !rx_clock_gating_in || detect_in;
      adc_ac_coupling_out <= rxtx[AC_COUPLE_BIT];
      tx_short_preamble_out <= rxtx[SHORT_PRE_BIT] || normal_short_preamble_reg_in;
      rx_short_preamble_out <= rxtx[SHORT_PRE_BIT] || normal_short_preamble_reg_in;
      use_preamble_length_reg_out <= rxtx[SHORT_PRE_BIT];
      channel_impulse_response_precursor_out <= rxtx[PRECURSOR_LSB +: PRECURSOR_W];
    end
  end

  // clear channel assessment
  cca_slot_if slot_bus ();

  assign slot_bus.sampled_mode      = rxtx[CCA_SAMPLED_BIT];
  assign slot_bus.sample_time_early = cca_sample_early_in;

  cca_slot_timer u_slot_timer (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .slot        (slot_bus.timer)
  );

  logic cs_or_sq;
  logic cca_raw;

  assign cs_or_sq = carrier_sense_in || signal_quality_in;

  always_comb
  begin
    case (cca_mode_in)
      2'h0:    cca_raw = energy_detect_in;
      2'h1:    cca_raw = cs_or_sq;
      2'h2:    cca_raw = energy_detect_in && cs_or_sq;
      default: cca_raw = energy_detect_in || cs_or_sq;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      clear_channel_out <= 1'b0;
    else if (!rxtx[CCA_SAMPLED_BIT])
      clear_channel_out <= cca_raw;
    else if (slot_bus.sample_pulse)
      clear_channel_out <= cca_raw;
  end

  // converter clocks and power-down controls
  logic [PD_W-1:0] pd_auto;
  logic            tx_off;
  logic            rx_off;

  assign tx_off = !transmit_power_enable_in;
  assign rx_off = !receive_power_enable_in;
  // order: standby, tx sleep, rx sleep, iq sleep, analog tx, analog rx, analog standby
  assign pd_auto = {tx_off && rx_off, tx_off, rx_off, tx_off && rx_off, tx_off, rx_off, tx_off && rx_off};

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      conv_clk_from_serial_data_in_pin_out <= 1'b0;
      conv_clk_enable_out                  <= '0;
      power_down_out                       <= '1;
    end
    else
    begin
      conv_clk_from_serial_data_in_pin_out <= clkt[CLK_SRC_BIT];
      conv_clk_enable_out <= ~clkt[CLK_GATE_W-1:0];
      if (pwr[MANUAL_PD_BIT])
        power_down_out <= pwr[PD_LSB +: PD_W];
      else
        power_down_out <= pd_auto;
    end
  end

  // converter output format
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      adc_i_out  <= '0;
      adc_q_out  <= '0;
      adc_rf_out <= '0;
    end
    else
    begin
      adc_i_out  <= fmt(adc_i_in, fmtr[FORMAT_BIT]);
      adc_q_out  <= fmt(adc_q_in, fmtr[FORMAT_BIT]);
      adc_rf_out <= fmt(adc_rf_in, fmtr[FORMAT_BIT]);
    end
  end

  // weight scan: even phase a weight, odd phase sync
  logic [CMF_PHASE_W-1:0] cmf_phase_q;
  logic [CONV_W-1:0]      cmf_word;
  localparam logic [CONV_W-1:0] NEG_FULL_SCALE = {1'b1, {(CONV_W-1){1'b0}}};

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      cmf_phase_q <= '0;
    else if (dac_sel_t'(fmtr[DAC_SEL_LSB +: DAC_SEL_W]) == DAC_CMF_WEIGHTS)
      cmf_phase_q <= cmf_phase_q + CMF_PHASE_W'(1);
    else
      cmf_phase_q <= '0;
  end

  assign cmf_word = cmf_phase_q[0] ? NEG_FULL_SCALE
                                   : channel_matched_filter_weights_in[cmf_phase_q[CMF_PHASE_W-1:1]*CONV_W +: CONV_W];

  // i/q dac source select
  logic [CONV_W-1:0] i_sel;
  logic [CONV_W-1:0] q_sel;

  always_comb
  begin
    case (dac_sel_t'(fmtr[DAC_SEL_LSB +: DAC_SEL_W]))
      DAC_TX_FILTER:
      begin
        i_sel = tx_filter_i_in;
        q_sel = tx_filter_q_in;
      end
      DAC_DOWNCONV:
      begin
        i_sel = downconv_i_in;
        q_sel = downconv_q_in;
      end
      DAC_CHIP_TIMING:
      begin
        i_sel = '0;
        q_sel = chip_timing_accumulator_in;
      end
      DAC_IQ_ADC:
      begin
        i_sel = adc_i_in;
        q_sel = adc_q_in;
      end
      DAC_PICKER:
      begin
        i_sel = picker_winner_inphase_in;
        q_sel = picker_winner_quadrature_in;
      end
      DAC_CMF_WEIGHTS:
      begin
        i_sel = cmf_word;
        q_sel = cmf_word;
      end
      DAC_TEST_BUS:
      begin
        i_sel = test_bus_in;
        q_sel = test_bus_in;
      end
      DAC_CORRELATOR:
      begin
        i_sel = correlator_i_in;
        q_sel = correlator_q_in;
      end
      default:
      begin
        i_sel = tx_filter_i_in;
        q_sel = tx_filter_q_in;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      i_dac_out               <= '0;
      q_dac_out               <= '0;
      rx_dac_out              <= '0;
      tx_dac_out              <= '0;
      reference_trim_high_out <= 1'b0;
      reference_trim_low_out  <= 1'b0;
    end
    else
    begin
      i_dac_out <= i_sel;
      q_dac_out <= q_sel;
      if (fmtr[RFADC_DAC_BIT])
        rx_dac_out <= adc_rf_in;
      else if (fmtr[TESTBUS_DAC_BIT])
        rx_dac_out <= test_bus_in;
      else
        rx_dac_out <= rx_dac_normal_in;
      if (!fmtr[RFADC_DAC_BIT] && fmtr[TESTBUS_DAC_BIT])
        tx_dac_out <= test_bus_in;
      else
        tx_dac_out <= tx_dac_normal_in;
      reference_trim_high_out <= fmtr[TRIM_HIGH_BIT];
      reference_trim_low_out  <= fmtr[TRIM_LOW_BIT];
    end
  end

  // agc attenuator accumulator, bounded by zero and the clip value
  logic signed [CLIP_W+1:0] acc_sum;
  logic [CLIP_W-1:0]        clip_lim;

  assign clip_lim = clip[CLIP_W-1:0];
  assign acc_sum  = $signed({2'b00, agc_attenuation_out}) + (CLIP_W+2)'(agc_step_in);

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      agc_attenuation_out <= '0;
    else if (agc_step_valid_in)
    begin
      if (acc_sum < 0)
        agc_attenuation_out <= '0;
      else if (acc_sum > $signed({2'b00, clip_lim}))
        agc_attenuation_out <= clip_lim;
      else
        agc_attenuation_out <= acc_sum[CLIP_W-1:0];
    end
    else if (agc_attenuation_out > clip_lim)
      agc_attenuation_out <= clip_lim;
  end

  // saturation thresholds
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      agc_mid_step_out <= 1'b0;
      agc_low_step_out <= 1'b0;
    end
    else
    begin
      agc_mid_step_out <= iq_saturation_count_in > SAT_CNT_W'(sat[SAT_MID_LSB +: SAT_W]);
      agc_low_step_out <= iq_saturation_count_in > SAT_CNT_W'(sat[SAT_LOW_LSB +: SAT_W]);
    end
  end

endmodule

// ===== sim/bb_cfg_checker.sv
// concurrent checks on the configuration bank ports
// assumes it is bound to the bank top
`timescale 1ns/1ps
module bb_cfg_checker
  import bb_cfg_pkg::*;
(
  input wire logic       core_clk_in,
  input wire logic       rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       rx_clock_gating_in,
  input wire logic       detect_in,
  input wire logic       rx_clk_run_out,
  input wire logic [5:0] test_bus_in,
  input wire logic [5:0] rx_dac_out,
  input wire logic [5:0] tx_dac_out,
  input wire logic [6:0] power_down_out,
  input wire logic [6:0] conv_clk_enable_out,
  input wire logic [6:0] agc_attenuation_out,
  input wire logic [7:0] iq_saturation_count_in,
  input wire logic       agc_mid_step_out,
  input wire logic       agc_low_step_out
);
  logic [7:0] sh_q [0:5];
  logic       map_w;
  logic [2:0] idx_w;
  assign map_w = !reg_addr_in[0] && reg_addr_in >= 8'h16 && reg_addr_in <= 8'h20;
  assign idx_w = 3'((reg_addr_in - 8'h16) >> 1);
  // shadow of the bank
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      sh_q <= '{default: REG_RESET_VALUE};
    else if (reg_wr_in && map_w)
      sh_q[idx_w] <= reg_wdata_in;
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_mapped_read;
    reg_rd_in && map_w;
  endsequence
  sequence s_testbus_sel;
    (sh_q[3][3:2] == 2'b10)[*2];
  endsequence
  property p_readback;
    s_mapped_read |=> reg_rdata_out == $past(sh_q[idx_w]);
  endproperty
  property p_rd_idle;
    !(reg_rd_in && map_w) |=> reg_rdata_out == 8'h00;
  endproperty
  property p_clk_run;
    1'b1 |=> rx_clk_run_out == $past(sh_q[0][7] | !rx_clock_gating_in | detect_in);
  endproperty
  property p_testbus;
    s_testbus_sel |-> rx_dac_out == $past(test_bus_in) && tx_dac_out == $past(test_bus_in);
  endproperty
  property p_manual_pd;
    sh_q[2][0] |=> power_down_out == $past(sh_q[2][7:1]);
  endproperty
  property p_clk_gate;
    1'b1 |=> conv_clk_enable_out == ~$past(sh_q[1][6:0]);
  endproperty
  property p_clip;
    $stable(sh_q[4]) |-> agc_attenuation_out <= sh_q[4][6:0];
  endproperty
  property p_sat;
    1'b1 |=> agc_mid_step_out == $past(iq_saturation_count_in > sh_q[5][7:4])
      && agc_low_step_out == $past(iq_saturation_count_in > sh_q[5][3:0]);
  endproperty
  a_readback: assert property (p_readback) else $error("bad readback");
  a_rd_idle: assert property (p_rd_idle) else $error("read not zero");
  a_clk_run: assert property (p_clk_run) else $error("bad rx clock");
  a_testbus: assert property (p_testbus) else $error("bad test bus dac");
  a_manual_pd: assert property (p_manual_pd) else $error("bad manual pd");
  a_clk_gate: assert property (p_clk_gate) else $error("bad clock gate");
  a_clip: assert property (p_clip) else $error("above clip");
  a_sat: assert property (p_sat) else $error("bad sat step");
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the configuration bank
// assumes default parameters
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("Error at %0t: got %0h want %0h", $time, a, b); end end
module tb_top;
  import bb_cfg_pkg::*;
  logic        core_clk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, detect_in = 1'b0;
  logic [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, iq_saturation_count_in = 8'h00, rd_q;
  logic        rx_clock_gating_in = 1'b1, normal_short_preamble_reg_in = 1'b0, energy_detect_in = 1'b0;
  logic        carrier_sense_in = 1'b0, signal_quality_in = 1'b0, cca_sample_early_in = 1'b0;
  logic [1:0]  cca_mode_in = 2'h0;
  logic        transmit_power_enable_in = 1'b1, receive_power_enable_in = 1'b0, agc_step_valid_in = 1'b0;
  logic signed [7:0] agc_step_in = 8'sh00;
  logic [5:0]  adc_i_in = 6'h0B, adc_q_in = 6'h0C, adc_rf_in = 6'h0D, tx_filter_i_in = 6'h01;
  logic [5:0]  tx_filter_q_in = 6'h02, downconv_i_in = 6'h03, downconv_q_in = 6'h04;
  logic [5:0]  chip_timing_accumulator_in = 6'h05, picker_winner_inphase_in = 6'h06;
  logic [5:0]  picker_winner_quadrature_in = 6'h07, correlator_i_in = 6'h08, correlator_q_in = 6'h09;
  logic [5:0]  test_bus_in = 6'h0A, rx_dac_normal_in = 6'h0E, tx_dac_normal_in = 6'h0F;
  logic [95:0] channel_matched_filter_weights_in;
  logic        rx_clk_run_out, adc_ac_coupling_out, tx_short_preamble_out, rx_short_preamble_out;
  logic        use_preamble_length_reg_out, clear_channel_out, conv_clk_from_serial_data_in_pin_out;
  logic [2:0]  channel_impulse_response_precursor_out;
  logic [6:0]  conv_clk_enable_out, power_down_out, agc_attenuation_out;
  logic [5:0]  adc_i_out, adc_q_out, adc_rf_out, i_dac_out, q_dac_out, rx_dac_out, tx_dac_out;
  logic        reference_trim_high_out, reference_trim_low_out, agc_mid_step_out, agc_low_step_out;
  logic [3:0]  m;
  int          bad_count = 0, tests_run = 0, cycles = 0, n;
  // address, write data, expected read data
  localparam logic [23:0] ROWS [8] = '{24'h185A5A, 24'h1AFEFE, 24'h1C3C3C, 24'h1E8585,
                                       24'h20F0F0, 24'h16A5A5, 24'h17FF00, 24'h227700};
  baseband_rxtx_test_agc_config uut (.*);
  always #5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
    tick(2);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 rd_q = reg_rdata_out;
  endtask
  task automatic step(input logic signed [7:0] s);
    @(posedge core_clk_in);
    agc_step_in       <= s;
    agc_step_valid_in <= 1'b1;
    @(posedge core_clk_in);
    agc_step_valid_in <= 1'b0;
    tick(1);
  endtask
  task automatic wait_cc(input logic v);
    n = 0;
    while (clear_channel_out !== v && n < 2100)
    begin
      tick(1);
      n++;
    end
  endtask
  function automatic logic [11:0] mux_exp(input logic [2:0] c);
    case (c)
      3'h0: return {tx_filter_i_in, tx_filter_q_in};
      3'h1: return {downconv_i_in, downconv_q_in};
      3'h2: return {6'h00, chip_timing_accumulator_in};
      3'h3: return {adc_i_in, adc_q_in};
      3'h4: return {picker_winner_inphase_in, picker_winner_quadrature_in};
      3'h6: return {2{test_bus_in}};
      default: return {correlator_i_in, correlator_q_in};
    endcase
  endfunction
  initial
  begin
    for (int k = 0; k < 16; k++)
      channel_matched_filter_weights_in[6*k +: 6] = 6'(k + 1);
    tick(2);
    `CHK({reg_rdata_out, power_down_out}, 15'h007F)
    tick(2);
    rst_in <= 1'b0;
    foreach (ROWS[i])
    begin
      wr(ROWS[i][23:16], ROWS[i][15:8]);
      rd(ROWS[i][23:16]);
      `CHK(rd_q, ROWS[i][7:0])
    end
    rd(8'h16);
    tick(1);
    `CHK({rd_q, reg_rdata_out}, 16'hA500)
    @(posedge core_clk_in);
    reg_addr_in  <= 8'h1E;
    reg_wdata_in <= 8'h8A;
    reg_wr_in    <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 `CHK(reg_rdata_out, 8'h8A)
    step(8'h07);
    step(8'h07);
    `CHK(agc_attenuation_out, 7'h0A)
    step(8'hEC);
    `CHK(agc_attenuation_out, 7'h00)
    wr(8'h20, 8'h53);
    for (int c = 3; c < 7; c++)
    begin
      iq_saturation_count_in <= 8'(c);
      tick(2);
      `CHK({agc_mid_step_out, agc_low_step_out}, {c > 5, c > 3})
    end
    wr(8'h16, 8'hD5);
    `CHK({rx_clk_run_out, adc_ac_coupling_out, tx_short_preamble_out, rx_short_preamble_out}, 4'hF)
    `CHK({use_preamble_length_reg_out, channel_impulse_response_precursor_out}, 4'hD)
    wr(8'h16, 8'h00);
    `CHK({rx_clk_run_out, adc_ac_coupling_out, tx_short_preamble_out}, 3'h0)
    detect_in <= 1'b1;
    normal_short_preamble_reg_in <= 1'b1;
    tick(2);
    `CHK({rx_clk_run_out, rx_short_preamble_out}, 2'h3)
    wr(8'h18, 8'hA9);
    `CHK({conv_clk_from_serial_data_in_pin_out, conv_clk_enable_out}, 8'hD6)
    wr(8'h1A, 8'hB3);
    `CHK(power_down_out, 7'h59)
    wr(8'h1A, 8'h00);
    `CHK(power_down_out, 7'h12)
    wr(8'h1C, 8'h83);
    `CHK({adc_i_out, adc_q_out, adc_rf_out, reference_trim_high_out, reference_trim_low_out}, {6'h2B, 6'h2C, 6'h2D, 2'h3})
    for (int c = 0; c < 8; c++)
      if (c != 5)
      begin
        wr(8'h1C, {1'b0, 3'(c), 4'h0});
        `CHK({i_dac_out, q_dac_out}, mux_exp(3'(c)))
      end
    wr(8'h1C, 8'h50);
    n = 0;
    while (i_dac_out !== 6'h01 && n < 40)
    begin
      tick(1);
      n++;
    end
    for (int p = 0; p < 32; p++)
    begin
      `CHK({i_dac_out, q_dac_out}, {2{p[0] ? 6'h20 : 6'(p / 2 + 1)}})
      tick(1);
    end
    wr(8'h1C, 8'h08);
    `CHK({rx_dac_out, tx_dac_out}, {2{test_bus_in}})
    wr(8'h1C, 8'h0C);
    `CHK({rx_dac_out, tx_dac_out}, {adc_rf_in, tx_dac_normal_in})
    for (int v = 0; v < 32; v++)
    begin
      {cca_mode_in, energy_detect_in, carrier_sense_in, signal_quality_in} <= 5'(v);
      tick(2);
      m = {v[2] | v[1] | v[0], v[2] & (v[1] | v[0]), v[1] | v[0], v[2]};
      `CHK(clear_channel_out, m[v[4:3]])
    end
    cca_mode_in <= 2'h0;
    for (int e = 0; e < 2; e++)
    begin
      energy_detect_in <= 1'b0;
      cca_sample_early_in <= 1'(e);
      wr(8'h16, 8'h00);
      wr(8'h16, 8'h08);
      energy_detect_in <= 1'b1;
      wait_cc(1'b1);
      `CHK(n >= 1864 - 290 * e && n <= 1874 - 290 * e, 1'b1)
      energy_detect_in <= 1'b0;
      wait_cc(1'b0);
      `CHK(n >= 1996 && n <= 2002, 1'b1)
    end
    give_verdict();
  end
endmodule
bind baseband_rxtx_test_agc_config bb_cfg_checker chk (.*);
